//--- seg_ecc_guard.sv
// sram ecc guard: check bit generation, checking, repair, init and debug port
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "seg_map.svh"

module seg_ecc_guard (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        special_mode,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [9:0]  req_addr,
  input  wire logic [3:0]  req_be,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_invalid,
  output logic             rsp_wr_err,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             single_err_irq
);

  // ----------------------------------------------------------------
  // check bit arithmetic
  // ----------------------------------------------------------------
  function automatic logic [5:0] seg_ecc(input logic [15:0] d);
    seg_ecc[0] = ~(^(d & `SEG_MASK0));
    seg_ecc[1] = ~(^(d & `SEG_MASK1));
    seg_ecc[2] = ~(^(d & `SEG_MASK2));
    seg_ecc[3] = ~(^(d & `SEG_MASK3));
    seg_ecc[4] = ~(^(d & `SEG_MASK4));
    seg_ecc[5] = ~(^(d & `SEG_MASK5));
  endfunction

  // ----------------------------------------------------------------
  // syndrome decode
  // ----------------------------------------------------------------
  // column of data bit i: the check bits that this bit feeds
  function automatic logic [5:0] seg_col(input int i);
    logic [15:0] m0;
    logic [15:0] m1;
    logic [15:0] m2;
    logic [15:0] m3;
    logic [15:0] m4;
    logic [15:0] m5;
    m0 = `SEG_MASK0;
    m1 = `SEG_MASK1;
    m2 = `SEG_MASK2;
    m3 = `SEG_MASK3;
    m4 = `SEG_MASK4;
    m5 = `SEG_MASK5;
    seg_col = {m5[i], m4[i], m3[i], m2[i], m1[i], m0[i]};
  endfunction

  // syndrome: recomputed vs stored; the inversion cancels out.
  // every column has three bits set, so two flips never pass for one
  function automatic seg_pkg::seg_chk_t seg_check(input logic [21:0] e);
    logic [5:0] syn;
    seg_check.data = e[15:0];
    seg_check.sgl  = 1'b0;
    seg_check.dbl  = 1'b0;
    syn = seg_ecc(e[15:0]) ^ e[21:16];
    for (int i = 0; i < 16; i++) begin
      if (syn != 6'h00 && syn == seg_col(i)) begin
        seg_check.data[i] = ~e[i];
        seg_check.sgl     = 1'b1;
      end
    end
    // a lone flipped check bit is a one-hot syndrome
    if (syn != 6'h00 && (syn & (syn - 6'h01)) == 6'h00)
      seg_check.sgl = 1'b1;
    if (syn != 6'h00 && !seg_check.sgl)
      seg_check.dbl = 1'b1;
  endfunction

  function automatic logic [21:0] seg_entry(input logic [15:0] d);
    seg_entry = {seg_ecc(d), d};
  endfunction

  // a half is written whole when both of its bytes are enabled or neither is
  function automatic logic seg_whole(input logic [1:0] be2);
    seg_whole = (be2 == 2'h0) || (be2 == 2'h3);
  endfunction

  // enabled bytes come from the bus, the rest from the corrected old word
  function automatic logic [31:0] seg_merge(input logic [31:0] nw, input logic [31:0] od, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      seg_merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : od[b*8 +: 8];
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // one entry per half word: six check bits above sixteen data bits
  logic [21:0] mem_q [0:2047];

  seg_pkg::seg_regs_t s_q;
  seg_pkg::seg_regs_t s_d;

  logic              we_lo;
  logic              we_hi;
  logic [10:0]       wa_lo;
  logic [10:0]       wa_hi;
  logic [21:0]       wd_lo;
  logic [21:0]       wd_hi;
  logic [21:0]       rd_lo;
  logic [21:0]       rd_hi;
  logic [21:0]       rd_dbg;
  seg_pkg::seg_chk_t c_lo;
  seg_pkg::seg_chk_t c_hi;

  assign rd_lo  = mem_q[{s_q.addr, 1'b0}];
  assign rd_hi  = mem_q[{s_q.addr, 1'b1}];
  assign rd_dbg = mem_q[s_q.debug_pointer];
  assign c_lo   = seg_check(rd_lo);
  assign c_hi   = seg_check(rd_hi);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic full;
    logic part_lo;
    logic part_hi;
    logic set_wr;
    logic set_rd;
    logic sgl_ev;
    logic [31:0] old;
    full    = 1'b0;
    part_lo = 1'b0;
    part_hi = 1'b0;
    set_wr  = 1'b0;
    set_rd  = 1'b0;
    sgl_ev  = 1'b0;
    old     = 32'h0000_0000;
    s_d     = s_q;
    s_d.rsp_valid   = 1'b0;
    s_d.rsp_invalid = 1'b0;
    s_d.rsp_wr_err  = 1'b0;
    we_lo = 1'b0;
    we_hi = 1'b0;
    wa_lo = {s_q.addr, 1'b0};
    wa_hi = {s_q.addr, 1'b1};
    wd_lo = seg_entry(16'h0000);
    wd_hi = seg_entry(16'h0000);

    case (s_q.st)
      seg_pkg::SEG_INIT: begin
        // both halves of one word per cycle, so the walk takes 1024 cycles
        wa_lo = {s_q.init_cnt, 1'b0};
        wa_hi = {s_q.init_cnt, 1'b1};
        we_lo = 1'b1;
        we_hi = 1'b1;
        s_d.init_cnt = s_q.init_cnt + 10'h001;
        if (s_q.init_cnt == `SEG_LAST_WORD) begin
          s_d.init_done = 1'b1;
          s_d.ready     = 1'b1;
          s_d.st        = seg_pkg::SEG_IDLE;
        end
      end
      seg_pkg::SEG_IDLE: begin
        // debug work only borrows idle cycles that no bus request wants
        if (req_valid && s_q.ready) begin
          s_d.addr  = req_addr;
          s_d.be    = req_be;
          s_d.wdata = req_wdata;
          s_d.is_wr = req_write;
          s_d.ready = 1'b0;
          s_d.st    = seg_pkg::SEG_ACCESS;
        end else if (!req_valid && s_q.cmd_wr) begin
          wa_lo      = s_q.debug_pointer;
          wd_lo      = {s_q.dcheck, s_q.debug_raw_word};
          we_lo      = 1'b1;
          s_d.cmd_wr = 1'b0;
        end else if (!req_valid && s_q.cmd_rd) begin
          // raw word and check bits, deliberately left unchecked
          s_d.debug_raw_word  = rd_dbg[15:0];
          s_d.dcheck = rd_dbg[21:16];
          s_d.cmd_rd = 1'b0;
        end
      end
      seg_pkg::SEG_ACCESS: begin
        // on a write only a partly written half needs its old bytes, so only such a half is checked; a read checks both
        full    = seg_whole(s_q.be[1:0]) && seg_whole(s_q.be[3:2]);
        part_lo = !seg_whole(s_q.be[1:0]);
        part_hi = !seg_whole(s_q.be[3:2]);
        old     = {c_hi.data, c_lo.data};
        s_d.rsp_valid = 1'b1;
        s_d.ready     = 1'b1;
        s_d.st        = seg_pkg::SEG_IDLE;
        if (s_q.is_wr && full) begin
          we_lo = s_q.be[0];
          we_hi = s_q.be[2];
          wd_lo = seg_entry(s_q.wdata[15:0]);
          wd_hi = seg_entry(s_q.wdata[31:16]);
        end else if (s_q.is_wr) begin
          if ((part_lo && c_lo.dbl) || (part_hi && c_hi.dbl)) begin
            s_d.rsp_wr_err = 1'b1;
          end else begin
            s_d.mdata     = seg_merge(s_q.wdata, old, s_q.be);
            sgl_ev        = (part_lo && c_lo.sgl) || (part_hi && c_hi.sgl);
            s_d.fix_lo    = s_q.be[1] | s_q.be[0];
            s_d.fix_hi    = s_q.be[3] | s_q.be[2];
            s_d.rsp_valid = 1'b0;
            s_d.ready     = 1'b0;
            s_d.st        = seg_pkg::SEG_WRITE;
          end
        end else begin
          s_d.rsp_rdata   = old;
          s_d.rsp_invalid = c_lo.dbl | c_hi.dbl;
          sgl_ev          = c_lo.sgl | c_hi.sgl;
          // the write-back holds off the next request for one cycle
          if (sgl_ev && !s_q.repair_dis) begin
            s_d.mdata  = old;
            s_d.fix_lo = c_lo.sgl;
            s_d.fix_hi = c_hi.sgl;
            s_d.ready  = 1'b0;
            s_d.st     = seg_pkg::SEG_WRITE;
          end
        end
      end
      seg_pkg::SEG_WRITE: begin
        // a repairing read has already answered; only merge writes answer here
        we_lo = s_q.fix_lo;
        we_hi = s_q.fix_hi;
        wd_lo = seg_entry(s_q.mdata[15:0]);
        wd_hi = seg_entry(s_q.mdata[31:16]);
        s_d.rsp_valid = s_q.is_wr;
        s_d.ready     = 1'b1;
        s_d.st        = seg_pkg::SEG_IDLE;
      end
      default: begin
        s_d.st = seg_pkg::SEG_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    if (reg_wr) begin
      case (reg_addr)
        `SEG_OFF_CMD: begin
          if (special_mode) begin
            s_d.repair_dis = reg_wdata[`SEG_CMD_REPAIR_DIS];
            if (!s_q.cmd_wr && !s_q.cmd_rd) begin
              set_wr = reg_wdata[`SEG_CMD_DBG_WR];
              set_rd = reg_wdata[`SEG_CMD_DBG_RD] & ~set_wr;
            end
          end
        end
        `SEG_OFF_PTR:    s_d.debug_pointer   = reg_wdata[10:0];
        `SEG_OFF_DEBUG_RAW_WORD:  s_d.debug_raw_word  = reg_wdata[15:0];
        `SEG_OFF_DCHECK: s_d.dcheck = reg_wdata[5:0];
        `SEG_OFF_STATUS: begin
          if (reg_wdata[`SEG_STS_SGL_FLAG])
            s_d.sgl_flag = 1'b0;
        end
        `SEG_OFF_INTEN:  s_d.int_en = reg_wdata[`SEG_IEN_SGL];
        default: begin
        end
      endcase
    end
    // held until a later idle cycle after init
    if (set_wr)
      s_d.cmd_wr = 1'b1;
    if (set_rd)
      s_d.cmd_rd = 1'b1;

    // ----------------------------------------------------------------
    // error flag and interrupt
    // ----------------------------------------------------------------
    // hardware set wins over a clear in the same cycle
    if (sgl_ev)
      s_d.sgl_flag = 1'b1;
    s_d.irq = s_d.sgl_flag & s_d.int_en;


    // ----------------------------------------------------------------
    // register read data
    // ----------------------------------------------------------------
    // read data stand for one cycle only and are zero otherwise
    s_d.reg_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `SEG_OFF_CMD: begin
          s_d.reg_rdata[`SEG_CMD_REPAIR_DIS] = s_q.repair_dis;
          s_d.reg_rdata[`SEG_CMD_DBG_WR]     = s_q.cmd_wr;
          s_d.reg_rdata[`SEG_CMD_DBG_RD]     = s_q.cmd_rd;
        end
        `SEG_OFF_PTR:    s_d.reg_rdata[10:0] = s_q.debug_pointer;
        `SEG_OFF_DEBUG_RAW_WORD:  s_d.reg_rdata[15:0] = s_q.debug_raw_word;
        `SEG_OFF_DCHECK: s_d.reg_rdata[5:0]  = s_q.dcheck;
        `SEG_OFF_STATUS: begin
          s_d.reg_rdata[`SEG_STS_INIT_DONE] = s_q.init_done;
          s_d.reg_rdata[`SEG_STS_SGL_FLAG]  = s_q.sgl_flag;
        end
        `SEG_OFF_INTEN:  s_d.reg_rdata[`SEG_IEN_SGL] = s_q.int_en;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers and array write ports
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q            <= '0;
      s_q.st         <= seg_pkg::SEG_INIT;
      s_q.repair_dis <= `SEG_RST_REPAIR_DIS;
      s_q.int_en     <= `SEG_RST_INT_EN;
      s_q.debug_pointer       <= `SEG_RST_PTR;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // array is not reset; the init walk gives it defined contents
  always_ff @(posedge ref_clk) begin
    if (!rst && clk_en) begin
      if (we_lo)
        mem_q[wa_lo] <= wd_lo;
      if (we_hi)
        mem_q[wa_hi] <= wd_hi;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // each output is a bare register bit, so no decode glitches reach the bus
  assign req_ready      = s_q.ready;
  assign rsp_valid      = s_q.rsp_valid;
  assign rsp_rdata      = s_q.rsp_rdata;
  assign rsp_invalid    = s_q.rsp_invalid;
  assign rsp_wr_err     = s_q.rsp_wr_err;
  assign reg_rdata      = s_q.reg_rdata;
  assign single_err_irq = s_q.irq;

endmodule

//--- seg_map.svh
// register offsets, field positions, reset values and counts of the sram ecc guard
`ifndef SEG_MAP_SVH
`define SEG_MAP_SVH

// register offsets (byte addresses, one 32-bit word each)
`define SEG_OFF_CMD        8'h00
`define SEG_OFF_PTR        8'h04
`define SEG_OFF_DEBUG_RAW_WORD      8'h08
`define SEG_OFF_DCHECK     8'h0c
`define SEG_OFF_STATUS     8'h10
`define SEG_OFF_INTEN      8'h14

// debug_command_reg fields
`define SEG_CMD_REPAIR_DIS 7
`define SEG_CMD_DBG_WR     1
`define SEG_CMD_DBG_RD     0

// status and interrupt enable fields
`define SEG_STS_INIT_DONE  0
`define SEG_STS_SGL_FLAG   1
`define SEG_IEN_SGL        0

// check bit masks
`define SEG_MASK0          16'h443f
`define SEG_MASK1          16'h13c7
`define SEG_MASK2          16'he1d1
`define SEG_MASK3          16'hee60
`define SEG_MASK4          16'h3e8a
`define SEG_MASK5          16'h993c

// array geometry and init count
`define SEG_WORDS          1024
`define SEG_LAST_WORD      10'h3ff

// reset values
`define SEG_RST_REPAIR_DIS 1'b0
`define SEG_RST_INT_EN     1'b0
`define SEG_RST_PTR        11'h000

`endif

//--- seg_pkg.sv
// types shared by the sram ecc guard
package seg_pkg;

  typedef enum logic [1:0] {
    SEG_INIT,
    SEG_IDLE,
    SEG_ACCESS,
    SEG_WRITE
  } seg_state_t;

  // one checked half word
  typedef struct packed {
    logic [15:0] data;
    logic        sgl;
    logic        dbl;
  } seg_chk_t;

  typedef struct packed {
    seg_state_t  st;
    logic [9:0]  init_cnt;
    logic        init_done;
    logic [9:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic        is_wr;
    logic [31:0] mdata;
    logic        fix_lo;
    logic        fix_hi;
    logic        ready;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic        rsp_invalid;
    logic        rsp_wr_err;
    logic        cmd_wr;
    logic        cmd_rd;
    logic        repair_dis;
    logic [10:0] debug_pointer;
    logic [15:0] debug_raw_word;
    logic [5:0]  dcheck;
    logic        sgl_flag;
    logic        int_en;
    logic        irq;
    logic [31:0] reg_rdata;
  } seg_regs_t;

endpackage

//--- seg_bus_model.sv
// bus initiator model that issues requests to the sram ecc guard
`timescale 1ns/100ps
module seg_bus_model (
  input  wire logic        ref_clk,
  output logic             req_valid,
  output logic             req_write,
  output logic [9:0]       req_addr,
  output logic [3:0]       req_be,
  output logic [31:0]      req_wdata,
  input  wire logic        req_ready,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  input  wire logic        rsp_invalid,
  input  wire logic        rsp_wr_err
);
  initial begin
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr  = 10'h0;
    req_be    = 4'h0;
    req_wdata = 32'h0;
  end

  // the request stays up until an edge that sees ready; released address and data lines carry
  // the inverse so that nothing can lean on stale values; write and byte enables keep theirs
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] rd, output logic inv, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_write <= wr;
    req_addr  <= a;
    req_be    <= be;
    req_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!req_ready && n < 2000);
    req_valid <= 1'h0;
    req_addr  <= ~a;
    req_wdata <= ~d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!rsp_valid && n < 4000);
    rd  = rsp_rdata;
    inv = rsp_invalid;
    err = rsp_wr_err;
    ok  = rsp_valid;
  endtask
endmodule

//--- seg_ecc_guard_chk.sv
// port level assertions for the sram ecc guard
`timescale 1ns/100ps
`include "seg_map.svh"
module seg_ecc_guard_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [3:0]  req_be,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_invalid,
  input wire logic        rsp_wr_err,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        single_err_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire take   = clk_en && req_valid && req_ready;
  // a write is direct when each half is untouched or fully written
  wire full_w = (req_be[1:0] == 2'h0 || req_be[1:0] == 2'h3) && (req_be[3:2] == 2'h0 || req_be[3:2] == 2'h3);

  chk_init_busy: assert property ($fell(rst) |-> !req_ready [*8])
    else $error("request accepted during init");
  // cycles that a request has waited so far; a hang saturates the count
  logic [10:0] wait_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst || !(req_valid && !req_ready))
      wait_cnt <= 11'h000;
    else if (wait_cnt != 11'h7ff)
      wait_cnt <= wait_cnt + 11'h001;
  end

  chk_wait_bound: assert property (wait_cnt < 11'h44c)
    else $error("request never accepted");
  chk_read_answer: assert property (take && !req_write |=> !req_ready ##1 (rsp_valid && !rsp_wr_err))
    else $error("read answer late or wrong");
  chk_full_write: assert property (take && req_write && full_w |=>
    !rsp_valid ##1 (rsp_valid && !rsp_wr_err && !rsp_invalid))
    else $error("direct write answer wrong");
  chk_rmw_answer: assert property (take && req_write && !full_w |=> !rsp_valid ##[1:2] rsp_valid)
    else $error("merge write answer missing");
  chk_rmw_early: assert property (take && req_write && !full_w |=> ##1 (!rsp_valid || rsp_wr_err))
    else $error("merge write answered before write back");
  chk_err_pulse: assert property (rsp_wr_err |-> rsp_valid && !rsp_invalid ##1 !rsp_valid)
    else $error("write error without single answer");
  chk_invalid_pulse: assert property (rsp_invalid |-> rsp_valid ##1 !rsp_valid)
    else $error("invalid mark without single answer");
  chk_irq_masked: assert property (reg_wr && reg_addr == `SEG_OFF_INTEN && !reg_wdata[0] |->
    ##2 !single_err_irq)
    else $error("interrupt while disabled");
  chk_repair_gap: assert property (clk_en && rsp_valid && !req_ready |=> req_ready)
    else $error("repair write back held the bus too long");
endmodule

bind seg_ecc_guard seg_ecc_guard_chk u_chk (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid),
  .req_write(req_write), .req_be(req_be), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_invalid(rsp_invalid),
  .rsp_wr_err(rsp_wr_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .single_err_irq(single_err_irq));

//--- seg_ecc_guard_tb.sv
// self-checking bench for the sram ecc guard
`timescale 1ns/100ps
`include "seg_map.svh"
module seg_ecc_guard_tb;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic        clk_en = 1'h1;
  logic        special_mode = 1'h1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        rep = 1'h0;
  logic        req_valid, req_write, req_ready, rsp_valid, rsp_invalid, rsp_wr_err, single_err_irq;
  logic [9:0]  req_addr;
  logic [3:0]  req_be;
  logic [31:0] req_wdata, rsp_rdata, reg_rdata, v, w;
  int          num_errors = 0;
  int          checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  seg_ecc_guard u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .special_mode(special_mode),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_invalid(rsp_invalid),
    .rsp_wr_err(rsp_wr_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .single_err_irq(single_err_irq));
  seg_bus_model u_bus (.ref_clk(ref_clk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_be(req_be), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_invalid(rsp_invalid), .rsp_wr_err(rsp_wr_err));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [5:0] ecc(input logic [15:0] d);
    return ~{^(d & `SEG_MASK5), ^(d & `SEG_MASK4), ^(d & `SEG_MASK3),
             ^(d & `SEG_MASK2), ^(d & `SEG_MASK1), ^(d & `SEG_MASK0)};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic dbg(input logic [1:0] c);
    int n;
    wr(`SEG_OFF_CMD, {24'h0, rep, 5'h0, c});
    n = 0;
    do begin
      rd(`SEG_OFF_CMD, v);
      n++;
    end while (v[1:0] !== 2'h0 && n < 2000);
    check("cmd_clear", v, {24'h0, rep, 7'h0});
  endtask
  task automatic peek(input logic [10:0] hw);
    wr(`SEG_OFF_PTR, {21'h0, hw});
    dbg(2'h1);
    rd(`SEG_OFF_DEBUG_RAW_WORD, w);
    rd(`SEG_OFF_DCHECK, v);
  endtask
  task automatic poke(input logic [10:0] hw, input logic [15:0] d, input logic [5:0] c);
    wr(`SEG_OFF_PTR, {21'h0, hw});
    wr(`SEG_OFF_DEBUG_RAW_WORD, {16'h0, d});
    wr(`SEG_OFF_DCHECK, {26'h0, c});
    dbg(2'h2);
  endtask
  task automatic acc(input logic iw, input logic [9:0] a, input logic [3:0] be, input logic [31:0] d,
                     input logic [31:0] er, input logic ei, input logic ee);
    logic [31:0] r;
    logic        i, e, ok;
    u_bus.xfer(iw, a, be, d, r, i, e, ok);
    check("answer", {31'h0, ok}, 32'h1);
    check("invalid", {31'h0, i}, {31'h0, ei});
    check("wr_err", {31'h0, e}, {31'h0, ee});
    if (!iw && !ei) check("rdata", r, er);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_init;
    rd(`SEG_OFF_STATUS, v);
    check("init_busy", v, 32'h0);
    peek(11'h7ff);
    check("init_word", w, 32'h0);
    check("init_check", v, {26'h0, ecc(16'h0)});
    rd(`SEG_OFF_STATUS, v);
    check("init_done", v, 32'h1);
    $display("test init done");
  endtask
  task automatic t_rw;
    acc(1'h1, 10'h005, 4'hf, 32'h12345678, 32'h0, 1'h0, 1'h0);
    acc(1'h1, 10'h006, 4'hc, 32'hbeef0000, 32'h0, 1'h0, 1'h0);
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h12345678, 1'h0, 1'h0);
    acc(1'h0, 10'h006, 4'h0, 32'h0, 32'hbeef0000, 1'h0, 1'h0);
    peek(11'h00a);
    check("dbg_word", w, 32'h5678);
    check("dbg_check", v, {26'h0, ecc(16'h5678)});
    peek(11'h00b);
    check("dbg_check", v, {26'h0, ecc(16'h1234)});
    $display("test write read done");
  endtask
  task automatic t_rmw;
    acc(1'h1, 10'h005, 4'h2, 32'h0000ab00, 32'h0, 1'h0, 1'h0);
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h1234ab78, 1'h0, 1'h0);
    acc(1'h1, 10'h005, 4'h6, 32'h00cdef00, 32'h0, 1'h0, 1'h0);
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h12cdef78, 1'h0, 1'h0);
    peek(11'h00a);
    check("rmw_check", v, {26'h0, ecc(16'hef78)});
    $display("test merge write done");
  endtask
  task automatic t_repair;
    wr(`SEG_OFF_INTEN, 32'h1);
    poke(11'h00a, 16'hee78, ecc(16'hef78));
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h12cdef78, 1'h0, 1'h0);
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h12cdef78, 1'h0, 1'h0);
    rd(`SEG_OFF_STATUS, v);
    check("flag", v, 32'h3);
    check("irq", {31'h0, single_err_irq}, 32'h1);
    peek(11'h00a);
    check("repaired", w, 32'hef78);
    wr(`SEG_OFF_INTEN, 32'h0);
    wr(`SEG_OFF_STATUS, 32'h2);
    rd(`SEG_OFF_STATUS, v);
    check("flag_clr", v, 32'h1);
    check("irq_off", {31'h0, single_err_irq}, 32'h0);
    $display("test repair done");
  endtask
  task automatic t_norep;
    rep = 1'h1;
    wr(`SEG_OFF_CMD, 32'h80);
    poke(11'h00b, 16'h12c9, ecc(16'h12cd));
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h12cdef78, 1'h0, 1'h0);
    rd(`SEG_OFF_STATUS, v);
    check("flag", v, 32'h3);
    check("irq_mask", {31'h0, single_err_irq}, 32'h0);
    peek(11'h00b);
    check("kept", w, 32'h12c9);
    rep = 1'h0;
    wr(`SEG_OFF_CMD, 32'h0);
    wr(`SEG_OFF_STATUS, 32'h2);
    acc(1'h1, 10'h005, 4'h4, 32'h00550000, 32'h0, 1'h0, 1'h0);
    rd(`SEG_OFF_STATUS, v);
    check("rmw_flag", v, 32'h3);
    peek(11'h00b);
    check("rmw_word", w, 32'h1255);
    check("rmw_chk", v, {26'h0, ecc(16'h1255)});
    $display("test no repair done");
  endtask
  task automatic t_double;
    poke(11'h00a, 16'hef69, ecc(16'hef78));
    acc(1'h0, 10'h005, 4'h0, 32'h0, 32'h0, 1'h1, 1'h0);
    acc(1'h1, 10'h005, 4'h1, 32'h000000aa, 32'h0, 1'h0, 1'h1);
    peek(11'h00a);
    check("blocked", w, 32'hef69);
    acc(1'h1, 10'h005, 4'h8, 32'h77000000, 32'h0, 1'h0, 1'h0);
    peek(11'h00b);
    check("hi_only", w, 32'h7755);
    $display("test double error done");
  endtask
  task automatic t_cmd;
    @(posedge ref_clk);
    special_mode <= 1'h0;
    wr(`SEG_OFF_CMD, 32'h1);
    rd(`SEG_OFF_CMD, v);
    check("cmd_locked", v, 32'h0);
    @(posedge ref_clk);
    special_mode <= 1'h1;
    wr(`SEG_OFF_STATUS, 32'h2);
    wr(`SEG_OFF_PTR, 32'hc);
    wr(`SEG_OFF_DEBUG_RAW_WORD, 32'h0f0f);
    wr(`SEG_OFF_DCHECK, 32'h15);
    dbg(2'h3);
    rd(`SEG_OFF_STATUS, v);
    check("dbg_wr_flag", v, 32'h1);
    peek(11'h00c);
    check("both_word", w, 32'h0f0f);
    check("both_check", v, 32'h15);
    rd(`SEG_OFF_STATUS, v);
    check("dbg_rd_flag", v, 32'h1);
    rd(8'h3c, v);
    check("unmapped", v, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'h0;
    wr(`SEG_OFF_PTR, 32'h5);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    rd(`SEG_OFF_PTR, v);
    check("frozen_ptr", v, 32'hc);
    $display("test command done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    t_init;
    t_rw;
    t_rmw;
    t_repair;
    t_norep;
    t_double;
    t_cmd;
    end_of_test;
  end

  // the whole run needs well under two thousand cycles, most of them the init walk; this leaves wide margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    $display("Error watchdog expected done seen hang");
    end_of_test;
  end
endmodule
